// ===== logic/lsfs_core.sv
/*
 * simmer sequencing, pulse limiting and status outputs of an rf laser power module,
 * with an axi4-lite register slave and one level interrupt.
 * assumes pins arrive asynchronously from line receivers and detectors; aclk is 250 MHz.
 */
module lsfs_core (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire lsfs_pkg::lsfs_pins_s pins,
    output logic rf_drive,
    output logic simmer_pulse,
    output logic simmer_safe_width,
    output logic pulse_limit_warning,
    output logic reflected_power_limit,
    output logic irq
);
    // =====================================================================
    // helpers

    // byte-lane merge of a write into a 32-bit register image
    function automatic logic [31:0] lsfs_merge(input logic [31:0] old, input logic [31:0] data,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return res;
    endfunction : lsfs_merge

    // one decoder serves reads and the unmapped-address answer of writes
    function automatic logic lsfs_mapped(input logic [7:0] addr);
        return (addr[1:0] == 2'h0) && (addr <= lsfs_pkg::ADDR_IRQ_MASK);
    endfunction : lsfs_mapped

    function automatic logic [31:0] lsfs_read(input logic [7:0] addr, input lsfs_pkg::lsfs_state_s s);
        logic [31:0] v;
        v = 32'h00000000;
        unique case (addr)
            lsfs_pkg::ADDR_CTRL: v[0] = s.simmer_en;
            lsfs_pkg::ADDR_SIMMER_WIDTH: v[15:0] = s.simmer_width;
            lsfs_pkg::ADDR_MAX_PULSE: v[15:0] = s.max_pulse;
            lsfs_pkg::ADDR_DUTY_LIMIT: v[7:0] = s.duty_limit;
            lsfs_pkg::ADDR_BREAKDOWN_TIME: v[15:0] = s.breakdown_time;
            lsfs_pkg::ADDR_STATUS: v[11:0] = {s.sync2.beam_on, s.sync2.interlock_closed, s.sync2.power_good,
                                              s.sync2.feedback_ok, s.safe_mode, s.feedback_loss,
                                              s.discharge_loss, s.pulse_limit_warning,
                                              s.reflected_power_limit, s.simmer_pulse, s.rf_drive,
                                              s.simmer_safe_width};
            lsfs_pkg::ADDR_IRQ_STATUS: v[lsfs_pkg::IRQ_BITS-1:0] = s.irq_status;
            lsfs_pkg::ADDR_IRQ_MASK: v[lsfs_pkg::IRQ_BITS-1:0] = s.irq_mask;
            default: v = 32'h00000000;
        endcase
        return v;
    endfunction : lsfs_read

    lsfs_pkg::lsfs_state_s st;
    lsfs_pkg::lsfs_state_s next_st;

    // =====================================================================
    // next-state logic
    always_comb begin
        logic beam;
        logic ilk;
        logic pwr;
        logic run;
        logic allowed;
        logic idle_done;
        logic [15:0] width_eff;
        logic width_viol;
        logic duty_viol;
        logic vswr_active;
        logic do_write;
        logic [31:0] wv;
        logic [lsfs_pkg::IRQ_BITS-1:0] clr;
        logic [lsfs_pkg::IRQ_BITS-1:0] ev;

        next_st = st;
        clr = '0;
        ev = '0;
        wv = 32'h00000000;

        // two-flop synchronisers; only sync2 feeds logic
        next_st.sync1 = pins;
        next_st.sync2 = st.sync1;
        next_st.prev = st.sync2;
        beam = st.sync2.beam_on;
        ilk = st.sync2.interlock_closed;
        pwr = st.sync2.power_good;
        run = ilk && pwr;

        // 1 us enable from the divider
        next_st.tick = (st.div == lsfs_pkg::TICK_LAST);
        next_st.div = next_st.tick ? 8'h00 : st.div + 8'h01;

        // idle timer cleared while high and restarted at the fall
        if (beam) begin
            next_st.idle_us = 16'h0000;
        end else if (st.tick && st.idle_us < lsfs_pkg::SIMMER_PERIOD_US) begin
            next_st.idle_us = st.idle_us + 16'h0001;
        end
        // full quiet period before any new simmer pulse
        idle_done = !beam && (st.idle_us >= lsfs_pkg::SIMMER_PERIOD_US);
        // simmer runs on power with interlock closed and no beam-on
        allowed = st.simmer_en && run && idle_done;

        // feedback loss follows the feedback detector while powered
        next_st.feedback_loss = pwr && !st.sync2.feedback_ok;
        // narrow pulses when gas will not break down or feedback is gone
        width_eff = (st.safe_mode || st.feedback_loss) ? lsfs_pkg::SAFE_SIMMER_WIDTH : st.simmer_width;

        // simmer period counter; restarts whenever simmer is not allowed
        if (!allowed) begin
            next_st.sim_cnt = 16'h0000;
            next_st.got_ign = 1'b0;
        end else if (st.tick) begin
            next_st.sim_cnt = (st.sim_cnt == lsfs_pkg::SIMMER_PERIOD_US - 16'h0001) ? 16'h0000
                              : st.sim_cnt + 16'h0001;
        end
        next_st.simmer_pulse = allowed && (next_st.sim_cnt < width_eff);
        next_st.simmer_safe_width = st.safe_mode || st.feedback_loss;

        // judge each pulse at its last tick: ignition seen or not
        if (st.simmer_pulse && st.sync2.ignition) begin
            next_st.got_ign = 1'b1;
        end
        if (allowed && st.tick && st.sim_cnt == width_eff - 16'h0001) begin
            next_st.discharge_loss = !(st.got_ign || st.sync2.ignition);
            next_st.got_ign = 1'b0;
        end

        // breakdown timer; any ignition clears safe_mode, restoring the programmed width unless feedback is lost
        if (st.sync2.ignition || !allowed) begin
            next_st.no_ign_us = 16'h0000;
            if (st.sync2.ignition) begin
                next_st.safe_mode = 1'b0;
            end
        end else if (st.tick) begin
            if (st.no_ign_us >= st.breakdown_time) begin
                next_st.safe_mode = 1'b1;
            end else begin
                next_st.no_ign_us = st.no_ign_us + 16'h0001;
            end
        end

        // width of the current beam-on pulse, saturating at the maximum
        if (!beam) begin
            next_st.on_us = 16'h0000;
        end else if (st.tick && st.on_us < st.max_pulse) begin
            next_st.on_us = st.on_us + 16'h0001;
        end
        width_viol = beam && (st.on_us >= st.max_pulse);

        // duty bucket: fills by (100-d) per us on, drains by d per us off; flat at exactly d percent
        if (st.tick) begin
            if (beam) begin
                if (st.bucket <= lsfs_pkg::DUTY_BUCKET_CAP) begin
                    next_st.bucket = st.bucket + 24'(lsfs_pkg::DUTY_FULL - st.duty_limit);
                end
            end else begin
                next_st.bucket = (st.bucket > 24'(st.duty_limit)) ? st.bucket - 24'(st.duty_limit) : 24'h000000;
            end
        end
        duty_viol = st.bucket > lsfs_pkg::DUTY_BUCKET_CAP;

        // warning only for the violating part of a beam-on
        next_st.pulse_limit_warning = beam && ilk && (width_viol || duty_viol);
        // reflected protection active only while it cuts a beam-on
        vswr_active = beam && ilk && st.sync2.reflect_over;
        // simmer faults shown only while beam-on is low
        next_st.reflected_power_limit = beam ? vswr_active
                                        : (pwr && (st.discharge_loss || st.feedback_loss));
        // rf drive gated by interlock and every limiter
        next_st.rf_drive = beam && run && !(width_viol || duty_viol) && !st.sync2.reflect_over;

        // sticky events on rising edges; the interlock event on interlock_closed falling
        ev[lsfs_pkg::IRQ_DISCHARGE] = next_st.discharge_loss && !st.discharge_loss;
        ev[lsfs_pkg::IRQ_FEEDBACK] = next_st.feedback_loss && !st.feedback_loss;
        ev[lsfs_pkg::IRQ_SAFE] = next_st.safe_mode && !st.safe_mode;
        ev[lsfs_pkg::IRQ_PULSE_LIMIT] = next_st.pulse_limit_warning && !st.pulse_limit_warning;
        ev[lsfs_pkg::IRQ_REFLECT] = next_st.reflected_power_limit && !st.reflected_power_limit;
        ev[lsfs_pkg::IRQ_INTERLOCK] = st.prev.interlock_closed && !ilk;

        // =================================================================
        // axi4-lite write: address and data taken in either order
        if (s_axi_awvalid && st.awready) begin
            next_st.aw_got = 1'b1;
            next_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.w_got = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
        end
        do_write = st.aw_got && st.w_got && !st.bvalid;
        if (do_write) begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = lsfs_mapped(st.awaddr) ? lsfs_pkg::RESP_OKAY : lsfs_pkg::RESP_SLVERR;
            wv = lsfs_merge(lsfs_read(st.awaddr, st), st.wdata, st.wstrb);
            unique case (st.awaddr)
                lsfs_pkg::ADDR_CTRL: next_st.simmer_en = wv[0];
                lsfs_pkg::ADDR_SIMMER_WIDTH: next_st.simmer_width = wv[15:0];
                lsfs_pkg::ADDR_MAX_PULSE: next_st.max_pulse = wv[15:0];
                lsfs_pkg::ADDR_DUTY_LIMIT: next_st.duty_limit = (wv[7:0] > lsfs_pkg::DUTY_FULL) ? lsfs_pkg::DUTY_FULL
                                                                 : wv[7:0];
                lsfs_pkg::ADDR_BREAKDOWN_TIME: next_st.breakdown_time = wv[15:0];
                lsfs_pkg::ADDR_IRQ_STATUS: clr = st.wstrb[0] ? st.wdata[lsfs_pkg::IRQ_BITS-1:0] : '0;
                lsfs_pkg::ADDR_IRQ_MASK: next_st.irq_mask = wv[lsfs_pkg::IRQ_BITS-1:0];
                default: clr = '0;
            endcase
        end else if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        next_st.awready = !next_st.aw_got && !next_st.bvalid;
        next_st.wready = !next_st.w_got && !next_st.bvalid;

        // write-one-to-clear; a new event in the same cycle survives the clear
        next_st.irq_status = (st.irq_status & ~clr) | ev;
        next_st.irq = |(next_st.irq_status & next_st.irq_mask);

        // axi4-lite read: one outstanding, data one cycle after the address
        if (s_axi_arvalid && st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = lsfs_read(s_axi_araddr, st);
            next_st.rresp = lsfs_mapped(s_axi_araddr) ? lsfs_pkg::RESP_OKAY : lsfs_pkg::RESP_SLVERR;
        end else if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        // address accepted whenever no read data waits; arready resets low and rises one cycle after reset
        next_st.arready = !next_st.rvalid;
    end

    // =====================================================================
    // state register, synchronous active-low reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.simmer_en <= lsfs_pkg::RST_SIMMER_EN;
            st.simmer_width <= lsfs_pkg::RST_SIMMER_WIDTH;
            st.max_pulse <= lsfs_pkg::RST_MAX_PULSE;
            st.duty_limit <= lsfs_pkg::RST_DUTY_LIMIT;
            st.breakdown_time <= lsfs_pkg::RST_BREAKDOWN_TIME;
            st.irq_mask <= lsfs_pkg::RST_IRQ_MASK;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state flops
    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign rf_drive = st.rf_drive;
    assign simmer_pulse = st.simmer_pulse;
    assign simmer_safe_width = st.simmer_safe_width;
    assign pulse_limit_warning = st.pulse_limit_warning;
    assign reflected_power_limit = st.reflected_power_limit;
    assign irq = st.irq;
endmodule : lsfs_core

// ===== logic/lsfs_pkg.sv
/*
 * constants, pin carrier and state record of the laser simmer and fault status block.
 * assumes a single 250 MHz clock; all timing inside the block runs on a 1 us tick.
 */
package lsfs_pkg;
    // =====================================================================
    // timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int US_NS = 1000;
    localparam int TICK_CYCLES = US_NS / CLK_PERIOD_NS;
    localparam logic [7:0] TICK_LAST = 8'(TICK_CYCLES - 1);
    localparam logic [15:0] SIMMER_PERIOD_US = 16'h03E8;
    localparam logic [23:0] DUTY_BUCKET_CAP = 24'h0186A0;
    localparam logic [7:0] DUTY_FULL = 8'h64;

    // =====================================================================
    // register offsets (byte addresses)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SIMMER_WIDTH = 8'h04;
    localparam logic [7:0] ADDR_MAX_PULSE = 8'h08;
    localparam logic [7:0] ADDR_DUTY_LIMIT = 8'h0C;
    localparam logic [7:0] ADDR_BREAKDOWN_TIME = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;

    // =====================================================================
    // reset values and the safe simmer width
    localparam logic RST_SIMMER_EN = 1'h1;
    localparam logic [15:0] RST_SIMMER_WIDTH = 16'h000A;
    localparam logic [15:0] SAFE_SIMMER_WIDTH = 16'h0001;
    localparam logic [15:0] RST_MAX_PULSE = 16'h03E8;
    localparam logic [7:0] RST_DUTY_LIMIT = 8'h41;
    localparam logic [15:0] RST_BREAKDOWN_TIME = 16'h2710;
    localparam logic [5:0] RST_IRQ_MASK = 6'h00;

    // =====================================================================
    // interrupt bit positions (status and mask share the layout)
    localparam int IRQ_DISCHARGE = 0;
    localparam int IRQ_FEEDBACK = 1;
    localparam int IRQ_SAFE = 2;
    localparam int IRQ_PULSE_LIMIT = 3;
    localparam int IRQ_REFLECT = 4;
    localparam int IRQ_INTERLOCK = 5;
    localparam int IRQ_BITS = 6;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // pins from the receivers and detectors, all asynchronous to aclk
    typedef struct packed {
        logic beam_on;
        logic interlock_closed;
        logic power_good;
        logic ignition;
        logic feedback_ok;
        logic reflect_over;
    } lsfs_pins_s;

    // whole state of the block
    typedef struct packed {
        lsfs_pins_s sync1;
        lsfs_pins_s sync2;
        lsfs_pins_s prev;
        logic [7:0] div;
        logic tick;
        logic simmer_en;
        logic [15:0] simmer_width;
        logic [15:0] max_pulse;
        logic [7:0] duty_limit;
        logic [15:0] breakdown_time;
        logic [IRQ_BITS-1:0] irq_status;
        logic [IRQ_BITS-1:0] irq_mask;
        logic [15:0] idle_us;
        logic [15:0] sim_cnt;
        logic [15:0] no_ign_us;
        logic [15:0] on_us;
        logic [23:0] bucket;
        logic got_ign;
        logic safe_mode;
        logic discharge_loss;
        logic feedback_loss;
        logic simmer_pulse;
        logic simmer_safe_width;
        logic rf_drive;
        logic pulse_limit_warning;
        logic reflected_power_limit;
        logic irq;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } lsfs_state_s;
endpackage : lsfs_pkg

// ===== tb/lsfs_core_chk.sv
/*
 * checker for the simmer and fault status block: status outputs against pin levels.
 * assumes pins pass two sync flops and one output flop, so outputs trail pins by three edges.
 */
module lsfs_core_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire lsfs_pkg::lsfs_pins_s pins,
    input wire logic rf_drive,
    input wire logic simmer_pulse,
    input wire logic simmer_safe_width,
    input wire logic pulse_limit_warning,
    input wire logic reflected_power_limit,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // =====================================================================
    // pin to output relations; three steady samples cover the sync delay
    AST_INTLK_OFF: assert property (!pins.interlock_closed [*3] |=> !rf_drive && !simmer_pulse)
        else $error("drive or simmer active with interlock open");
    AST_NO_SIMMER: assert property (pins.beam_on [*3] |=> !simmer_pulse)
        else $error("simmer pulse while beam on");
    AST_REARM: assert property ($fell(pins.beam_on) |-> ##3 !simmer_pulse [*8])
        else $error("simmer pulse right after beam off");
    // feedback loss is itself a flop, so simmer-fault paths trail the pins by one more edge
    AST_REFL_SIMMER: assert property ((!pins.beam_on && pins.power_good && !pins.feedback_ok) [*4]
        |=> reflected_power_limit) else $error("simmer fault not shown on reflected limit");
    AST_REFL_REVERT: assert property ((pins.beam_on && !pins.reflect_over) [*3]
        |=> !reflected_power_limit) else $error("reflected limit shows simmer fault during beam");
    AST_SAFE_WIDTH: assert property ((pins.power_good && !pins.feedback_ok) [*4] |=> simmer_safe_width)
        else $error("feedback loss without safe width");
    AST_REFL_BEAM: assert property ((pins.beam_on && pins.interlock_closed && pins.reflect_over) [*3]
        |=> reflected_power_limit && !rf_drive) else $error("reflected overload not flagged");
    AST_WARN_EXCL: assert property (pulse_limit_warning |-> !rf_drive)
        else $error("warning high while drive passes");
    AST_WARN_LOW: assert property (!pins.beam_on [*3] |=> !pulse_limit_warning)
        else $error("pulse warning with beam off");

    // main scenarios reached
    cover property (pulse_limit_warning);
    cover property (pins.beam_on && reflected_power_limit);
    cover property ($fell(irq));
endmodule : lsfs_core_chk

bind lsfs_core lsfs_core_chk i_lsfs_core_chk (.aclk, .aresetn, .pins, .rf_drive, .simmer_pulse,
    .simmer_safe_width, .pulse_limit_warning, .reflected_power_limit, .irq);

// ===== tb/lsfs_core_tb.sv
/*
 * self-checking bench for the simmer and fault status block with its axi4-lite registers.
 * assumes 250 MHz aclk; simmer re-arm takes 250000 cycles, so only its absence is checked.
 */
module lsfs_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0;
    logic aresetn = 0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic s_axi_bready = 1, s_axi_rready = 1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [31:0] s_axi_rdata, rd;
    // interlock closed, power good, feedback ok
    lsfs_pkg::lsfs_pins_s cmd = 6'h1A;
    lsfs_pkg::lsfs_pins_s pins;
    logic rf_drive, simmer_pulse, simmer_safe_width, pulse_limit_warning, reflected_power_limit, irq;
    logic refl_valid;
    int failures = 0;
    int checks_done = 0;

    // 4 ns period
    always #2 aclk = ~aclk;

    lsfs_core i_lsfs_core (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pins, .rf_drive, .simmer_pulse,
        .simmer_safe_width, .pulse_limit_warning, .reflected_power_limit, .irq);
    lsfs_host i_lsfs_host (.aclk, .cmd, .pins, .refl_valid);

    // =====================================================================
    // helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wt(input int n);
        repeat (n) @(posedge aclk);
    endtask : wt

    // address and data offered together, each released when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_done;
        logic w_done;
        aw_done = 0;
        w_done = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        // local flags: the valid signals themselves still read old values in this time step
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (!aw_done && s_axi_awready) begin
                aw_done = 1;
                s_axi_awvalid <= 0;
            end
            if (!w_done && s_axi_wready) begin
                w_done = 1;
                s_axi_wvalid <= 0;
            end
        end
        while (!s_axi_bvalid) @(posedge aclk);
        rr = s_axi_bresp;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 0;
        do @(posedge aclk); while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
    endtask : axi_rd

    // =====================================================================
    // scenarios
    task automatic t_reset();
        logic [7:0] ad [5] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h1C};
        logic [31:0] ex [5] = '{32'(lsfs_pkg::RST_SIMMER_WIDTH), 32'(lsfs_pkg::RST_MAX_PULSE),
            32'(lsfs_pkg::RST_DUTY_LIMIT), 32'(lsfs_pkg::RST_BREAKDOWN_TIME), 32'(lsfs_pkg::RST_IRQ_MASK)};
        chk(32'({rf_drive, simmer_pulse, pulse_limit_warning, reflected_power_limit, irq}), 32'h0);
        axi_wr(lsfs_pkg::ADDR_CTRL, 32'h1);
        chk(32'(rr), 32'(lsfs_pkg::RESP_OKAY));
        for (int i = 0; i < 5; i++) begin
            axi_rd(ad[i]);
            chk(rd, ex[i]);
        end
        axi_rd(lsfs_pkg::ADDR_CTRL);
        chk(rd, 32'h1);
        // interlock, power and feedback good, everything else quiet
        axi_rd(lsfs_pkg::ADDR_STATUS);
        chk(rd, 32'h00000700);
        axi_rd(8'h20);
        chk(rd, 32'h0);
        chk(32'(rr), 32'(lsfs_pkg::RESP_SLVERR));
        axi_wr(8'h24, 32'h5);
        chk(32'(rr), 32'(lsfs_pkg::RESP_SLVERR));
        $display("test reset done");
    endtask : t_reset

    task automatic t_pulse();
        axi_wr(lsfs_pkg::ADDR_MAX_PULSE, 32'h5);
        cmd.beam_on <= 1;
        wt(750);
        chk({rf_drive, pulse_limit_warning, simmer_pulse}, 3'b100);
        wt(1500);
        chk({rf_drive, pulse_limit_warning}, 2'b01);
        cmd.beam_on <= 0;
        wt(8);
        chk({pulse_limit_warning, simmer_pulse}, 2'b00);
        wt(1000);
        chk(simmer_pulse, 1'b0);
        $display("test pulse done");
    endtask : t_pulse

    task automatic t_reflect();
        cmd.beam_on <= 1;
        cmd.reflect_over <= 1;
        do @(posedge aclk); while (!refl_valid);
        wt(8);
        chk({reflected_power_limit, rf_drive}, 2'b10);
        cmd.reflect_over <= 0;
        wt(8);
        chk({reflected_power_limit, rf_drive}, 2'b01);
        cmd.beam_on <= 0;
        wt(8);
        $display("test reflect done");
    endtask : t_reflect

    task automatic t_irq();
        axi_wr(lsfs_pkg::ADDR_IRQ_STATUS, 32'h3F);
        axi_wr(lsfs_pkg::ADDR_IRQ_MASK, 32'h2);
        cmd.feedback_ok <= 0;
        wt(8);
        chk({reflected_power_limit, simmer_safe_width, irq}, 3'b111);
        cmd.beam_on <= 1;
        wt(8);
        chk(reflected_power_limit, 1'b0);
        cmd.beam_on <= 0;
        cmd.feedback_ok <= 1;
        wt(8);
        chk({simmer_safe_width, irq}, 2'b01);
        axi_wr(lsfs_pkg::ADDR_IRQ_STATUS, 32'h2);
        wt(4);
        chk(irq, 1'b0);
        $display("test irq done");
    endtask : t_irq

    task automatic t_intlk();
        axi_wr(lsfs_pkg::ADDR_IRQ_STATUS, 32'h3F);
        cmd.beam_on <= 1;
        wt(8);
        chk(rf_drive, 1'b1);
        cmd.interlock_closed <= 0;
        wt(8);
        chk({rf_drive, simmer_pulse, irq}, 3'b000);
        axi_rd(lsfs_pkg::ADDR_IRQ_STATUS);
        chk(rd, 32'h20);
        cmd.beam_on <= 0;
        cmd.interlock_closed <= 1;
        wt(8);
        $display("test interlock done");
    endtask : t_intlk

    task automatic end_sim();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    // main sequence
    initial begin
        wt(8);
        aresetn <= 1;
        wt(2);
        t_reset();
        t_pulse();
        t_reflect();
        t_irq();
        t_intlk();
        end_sim();
    end

    // hang guard, about ten times the expected run
    initial begin
        wt(40000);
        failures++;
        end_sim();
    end
endmodule : lsfs_core_tb

// ===== tb/lsfs_host.sv
/*
 * host controller model: drives the pin bundle of the simmer and status block.
 * assumes the bench names the wanted levels; they reach the pins one edge later.
 */
module lsfs_host #(
    parameter int SETTLE = 16
) (
    input wire logic aclk,
    input wire lsfs_pkg::lsfs_pins_s cmd,
    output lsfs_pkg::lsfs_pins_s pins,
    output logic refl_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    lsfs_pkg::lsfs_pins_s line = '0;
    int on_cnt = 0;

    // lines change just after an edge, like a real driver
    always @(posedge aclk) begin
        line <= cmd;
    end
    assign pins = line;

    // ignore startup
    // reflected limit is only trusted once the beam has been on a while
    always @(posedge aclk) begin
        on_cnt <= line.beam_on ? on_cnt + 1 : 0;
    end
    assign refl_valid = (on_cnt >= SETTLE);
endmodule : lsfs_host
